// *** common/smid_regs.svh ***
// constants for the security memory and identification client and its host controller
`ifndef SMID_REGS_SVH
`define SMID_REGS_SVH

// ==========================================================================
// host controller register map (byte addresses on the AHB-Lite slave)
`define SMID_CMD_OFS         8'h00
`define SMID_STATUS_OFS      8'h04
`define SMID_DIV_OFS         8'h08

// command register fields; bits 7:0 carry the byte to send
`define SMID_CMD_START_BIT   8
`define SMID_CMD_WRITE_BIT   9
`define SMID_CMD_READ_BIT    10
`define SMID_CMD_STOP_BIT    11
`define SMID_CMD_NACK_BIT    12

// status register fields; bits 15:8 carry the last byte received
`define SMID_STAT_BUSY_BIT   0
`define SMID_STAT_ACK_BIT    1
`define SMID_STAT_RX_LSB     8

// clock cycles per quarter of a link bit, less one
`define SMID_DIV_RESET       8'h08

// ==========================================================================
// link codes
`define SMID_SEC_TYPE        4'hB
`define SMID_ID_TYPE         4'hA
`define SMID_ID_QUERY        8'hF8
`define SMID_ID_READ         8'hF9
`define SMID_LOCK_NIBBLE     4'h6

// ==========================================================================
// timing
`define SMID_CLK_PERIOD_NS   10
`define SMID_WRITE_TIME_NS   10000
`define SMID_WRITE_CYCLE_CLKS ((`SMID_WRITE_TIME_NS + `SMID_CLK_PERIOD_NS - 1) / `SMID_CLK_PERIOD_NS)

`endif

// *** common/smid_pkg.sv ***
// types shared by the client and the host controller
package smid_pkg;

	typedef enum logic [3:0] {
		DS_IDLE,
		DS_DEV,
		DS_AH,
		DS_AL,
		DS_WR,
		DS_RD,
		DS_IDDEV,
		DS_IDRD,
		DS_SKIP
	} smid_dev_state_e;

	typedef enum logic [1:0] {
		HS_IDLE,
		HS_START,
		HS_BIT,
		HS_STOP
	} smid_host_state_e;

endpackage : smid_pkg

// *** common/smid_if.sv ***
// two-wire link between the host controller and the client, open-drain resolved here
`timescale 1ns/1ps
interface smid_if;
	logic scl_oe;      // host pulls clock low
	logic host_sda_oe; // host pulls data low
	logic dev_sda_oe;  // client pulls data low
	logic scl;         // resolved clock line
	logic sda;         // resolved data line

	// pull-ups: a line is low only while someone drives it
	assign scl = ~scl_oe;
	assign sda = ~(host_sda_oe | dev_sda_oe);

	modport host (
		output scl_oe,
		output host_sda_oe,
		input  scl,
		input  sda
	);

	modport device (
		output dev_sda_oe,
		input  scl,
		input  sda
	);
endinterface : smid_if

// *** verilog/smid_device.sv ***
// two-wire client: security memory with lock, and identification query
// ==========================================================================
// Summary of operation
// - security reads use type 1011 and matching pins
// - security addresses: bit15=0, bit10=0, bit11=1
// - no current-address read of security memory
// - serial number and reserved lower page read-only
// - upper page byte and page writes, page wrap
// - host ends prior transaction with stop first
// - address 0800h reaches first serial byte
// - sequential read wraps after byte 255
// - read ends on host nack then stop
// - protect pin or lock: no write, ready
// - zone protection ignored for security writes
// - lock is byte write with nibble 0110
// - cut-short lock sequence aborts, stays unlocked
// - lock bytes acked only while unlocked
// - stop starts write cycle, then permanent lock
// - lock ignores the protect pin
// - lock check: ack unlocked, nack locked
// - host sends no more bytes during check
// - F8h, device byte, repeated start, F9h
// - stop between query steps cancels identification
// - three id bytes, msb first, wrapping
// - id holds maker, density, revision fields
// - user page unlocked and FFh when delivered
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "smid_regs.svh"
module smid_device #(
	parameter logic [127:0] SERIAL_NUMBER    = 128'h0123456789ABCDEF0123456789ABCDEF, // arbitrary value
	parameter logic [11:0]  MAKER_CODE       = 12'hA5C,                   // arbitrary value
	parameter logic [8:0]   DENSITY_CODE     = 9'h15A,                    // arbitrary value
	parameter logic [2:0]   REVISION_CODE    = 3'h1,                      // arbitrary value
	parameter int           WRITE_CYCLE_CLKS = `SMID_WRITE_CYCLE_CLKS     // self-timed write length
) (
	input  wire logic  i_clock,               // system clock
	input  wire logic  i_reset,               // async reset, active high
	smid_if.device     bus,                   // two-wire link
	input  wire logic  i_client_select_pin_2, // client select strap
	input  wire logic  i_client_select_pin_1, // client select strap
	input  wire logic  i_client_select_pin_0, // client select strap
	input  wire logic  i_write_protect,       // write-protect pin
	output logic       o_locked,              // user page locked
	output logic       o_busy                 // internal write cycle running
);

	// ==========================================================================
	// storage
	logic [7:0]   mem_reg [0:255];
	logic [7:0]   buf_reg [0:127];
	logic [127:0] mask_reg;
	logic         locked_reg;
	logic         busy_reg;
	logic [31:0]  wcnt_reg;

	// ==========================================================================
	// pin synchronisers; stage 0 is read only by stage 1
	logic [2:0] scl_sync;
	logic [2:0] sda_sync;
	logic [1:0] wp_sync;
	logic [2:0] sel_s1;
	logic [2:0] sel_s2;

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
			wp_sync  <= 2'h0;
			sel_s1   <= 3'h0;
			sel_s2   <= 3'h0;
		end else begin
			scl_sync <= {scl_sync[1:0], bus.scl};
			sda_sync <= {sda_sync[1:0], bus.sda};
			wp_sync  <= {wp_sync[0], i_write_protect};
			sel_s1   <= {i_client_select_pin_2, i_client_select_pin_1, i_client_select_pin_0};
			sel_s2   <= sel_s1;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	assign scl_rise  = scl_sync[1] & ~scl_sync[2];
	assign scl_fall  = ~scl_sync[1] & scl_sync[2];
	assign start_det = scl_sync[1] & scl_sync[2] & sda_sync[2] & ~sda_sync[1];
	assign stop_det  = scl_sync[1] & scl_sync[2] & ~sda_sync[2] & sda_sync[1];

	// ==========================================================================
	// identification bytes
	function automatic logic [7:0] id_byte(input logic [1:0] idx);
		logic [23:0] id;
		id = {MAKER_CODE, DENSITY_CODE, REVISION_CODE};
		if (idx == 2'h0) begin
			id_byte = id[23:16];
		end else if (idx == 2'h1) begin
			id_byte = id[15:8];
		end else begin
			id_byte = id[7:0];
		end
	endfunction : id_byte

	// ==========================================================================
	// link protocol
	smid_pkg::smid_dev_state_e state_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] tx_reg;
	logic       sda_oe_reg;
	logic [7:0] ptr_reg;
	logic       addr_ok_reg;
	logic       clean_reg;
	logic       id_armed_reg;
	logic [1:0] id_idx_reg;
	logic       lock_seq_reg;
	logic       lock_armed_reg;
	logic       pend_reg;
	logic       commit_go_reg;
	logic       commit_lock_reg;
	logic       host_ack_reg;
	logic       dev_acked_reg;

	logic [7:0] rx;
	logic       sel_match;
	logic       reading;
	logic [1:0] id_idx_next;
	logic [7:0] rd_next;
	assign rx          = shift_reg;
	assign sel_match   = (rx[3:1] == sel_s2);
	assign reading     = (state_reg == smid_pkg::DS_RD) || (state_reg == smid_pkg::DS_IDRD);
	assign id_idx_next = (id_idx_reg == 2'h2) ? 2'h0 : id_idx_reg + 2'h1;
	assign rd_next     = (state_reg == smid_pkg::DS_RD) ? mem_reg[ptr_reg + 8'h01] : id_byte(id_idx_next);

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			state_reg       <= smid_pkg::DS_IDLE;
			bit_cnt_reg     <= 4'h0;
			shift_reg       <= 8'h00;
			tx_reg          <= 8'h00;
			sda_oe_reg      <= 1'b0;
			ptr_reg         <= 8'h00;
			addr_ok_reg     <= 1'b0;
			clean_reg       <= 1'b1;
			id_armed_reg    <= 1'b0;
			id_idx_reg      <= 2'h0;
			lock_seq_reg    <= 1'b0;
			lock_armed_reg  <= 1'b0;
			pend_reg        <= 1'b0;
			commit_go_reg   <= 1'b0;
			commit_lock_reg <= 1'b0;
			host_ack_reg    <= 1'b0;
			dev_acked_reg   <= 1'b0;
			mask_reg        <= 128'h0;
		end else begin
			commit_go_reg <= 1'b0;
			if (start_det) begin
				// a repeated start abandons any write or lock in progress
				// the clock fall that closes the start is absorbed like the end of an ack slot
				state_reg      <= smid_pkg::DS_DEV;
				bit_cnt_reg    <= 4'h8;
				sda_oe_reg     <= 1'b0;
				pend_reg       <= 1'b0;
				lock_armed_reg <= 1'b0;
			end else if (stop_det) begin
				state_reg    <= smid_pkg::DS_IDLE;
				sda_oe_reg   <= 1'b0;
				clean_reg    <= 1'b1;
				id_armed_reg <= 1'b0;
				addr_ok_reg  <= 1'b0;
				if (pend_reg || lock_armed_reg) begin
					commit_go_reg   <= 1'b1;
					commit_lock_reg <= lock_armed_reg;
				end
				pend_reg       <= 1'b0;
				lock_armed_reg <= 1'b0;
			end else if (state_reg != smid_pkg::DS_IDLE) begin
				if (scl_rise) begin
					if (bit_cnt_reg[3]) begin
						host_ack_reg <= ~sda_sync[1];
					end else begin
						shift_reg <= {shift_reg[6:0], sda_sync[1]};
					end
				end else if (scl_fall) begin
					if (bit_cnt_reg == 4'h7) begin
						bit_cnt_reg <= 4'h8;
						sda_oe_reg  <= 1'b0;
						case (state_reg)
							smid_pkg::DS_DEV: begin
								clean_reg    <= 1'b0;
								id_armed_reg <= 1'b0;
								if (rx == `SMID_ID_QUERY) begin
									sda_oe_reg <= 1'b1;
									state_reg  <= smid_pkg::DS_IDDEV;
								end else if (id_armed_reg && rx == `SMID_ID_READ) begin
									sda_oe_reg    <= 1'b1;
									tx_reg        <= id_byte(2'h0);
									id_idx_reg    <= 2'h0;
									dev_acked_reg <= 1'b1;
									state_reg     <= smid_pkg::DS_IDRD;
								end else if (rx[7:4] == `SMID_SEC_TYPE && sel_match && !busy_reg
										&& (clean_reg || addr_ok_reg)) begin
									if (!rx[0]) begin
										sda_oe_reg <= 1'b1;
										state_reg  <= smid_pkg::DS_AH;
									end else if (addr_ok_reg) begin
										sda_oe_reg    <= 1'b1;
										tx_reg        <= mem_reg[ptr_reg];
										dev_acked_reg <= 1'b1;
										state_reg     <= smid_pkg::DS_RD;
									end else begin
										state_reg <= smid_pkg::DS_SKIP;
									end
								end else begin
									state_reg <= smid_pkg::DS_SKIP;
								end
							end
							smid_pkg::DS_IDDEV: begin
								if (rx[7:4] == `SMID_ID_TYPE && sel_match) begin
									id_armed_reg <= 1'b1;
									sda_oe_reg   <= 1'b1;
								end
								state_reg <= smid_pkg::DS_SKIP;
							end
							smid_pkg::DS_AH: begin
								addr_ok_reg  <= 1'b0;
								lock_seq_reg <= (rx[3:0] == `SMID_LOCK_NIBBLE);
								if (rx[3:0] == `SMID_LOCK_NIBBLE) begin
									sda_oe_reg <= !locked_reg;
									state_reg  <= locked_reg ? smid_pkg::DS_SKIP : smid_pkg::DS_AL;
								end else if (!rx[7] && rx[3] && !rx[2]) begin
									sda_oe_reg <= 1'b1;
									state_reg  <= smid_pkg::DS_AL;
								end else begin
									state_reg <= smid_pkg::DS_SKIP;
								end
							end
							smid_pkg::DS_AL: begin
								ptr_reg     <= rx;
								addr_ok_reg <= !lock_seq_reg;
								mask_reg    <= 128'h0;
								sda_oe_reg  <= 1'b1;
								state_reg   <= smid_pkg::DS_WR;
							end
							smid_pkg::DS_WR: begin
								sda_oe_reg <= 1'b1;
								if (lock_seq_reg) begin
									lock_armed_reg <= 1'b1;
								end else begin
									// zone protection has no say here; only the upper page bit, the pin and the lock gate it
									if (ptr_reg[7] && !locked_reg && !wp_sync[1]) begin
										buf_reg[ptr_reg[6:0]]  <= rx;
										mask_reg[ptr_reg[6:0]] <= 1'b1;
										pend_reg               <= 1'b1;
									end
									ptr_reg <= {ptr_reg[7], ptr_reg[6:0] + 7'h01};
								end
							end
							default: begin
								sda_oe_reg <= 1'b0;
							end
						endcase
					end else if (bit_cnt_reg[3]) begin
						bit_cnt_reg   <= 4'h0;
						dev_acked_reg <= 1'b0;
						sda_oe_reg    <= 1'b0;
						if (reading) begin
							if (dev_acked_reg) begin
								sda_oe_reg <= ~tx_reg[7];
							end else if (host_ack_reg) begin
								if (state_reg == smid_pkg::DS_RD) begin
									ptr_reg <= ptr_reg + 8'h01;
								end else begin
									id_idx_reg <= id_idx_next;
								end
								tx_reg     <= rd_next;
								sda_oe_reg <= ~rd_next[7];
							end else begin
								state_reg <= smid_pkg::DS_SKIP;
							end
						end
					end else begin
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
						if (reading) begin
							tx_reg     <= {tx_reg[6:0], 1'b0};
							sda_oe_reg <= ~tx_reg[6];
						end
					end
				end
			end
		end
	end

	// ==========================================================================
	// self-timed write cycle and lock
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			busy_reg   <= 1'b0;
			wcnt_reg   <= 32'h0;
			locked_reg <= 1'b0;
			for (int i = 0; i < 256; i++) begin
				mem_reg[i] <= (i < 16) ? SERIAL_NUMBER[127 - 8 * i -: 8] : 8'hFF;
			end
		end else if (commit_go_reg) begin
			busy_reg <= 1'b1;
			wcnt_reg <= 32'(WRITE_CYCLE_CLKS - 1);
		end else if (busy_reg) begin
			if (wcnt_reg == 32'h0) begin
				busy_reg <= 1'b0;
				if (commit_lock_reg) begin
					locked_reg <= 1'b1;
				end else begin
					for (int i = 0; i < 128; i++) begin
						if (mask_reg[i]) begin
							mem_reg[128 + i] <= buf_reg[i];
						end
					end
				end
			end else begin
				wcnt_reg <= wcnt_reg - 32'h1;
			end
		end
	end

	assign bus.dev_sda_oe = sda_oe_reg;
	assign o_locked       = locked_reg;
	assign o_busy         = busy_reg;

endmodule : smid_device

// *** verilog/smid_host.sv ***
// two-wire host controller driven byte by byte through AHB-Lite registers
`timescale 1ns/1ps
`include "smid_regs.svh"
module smid_host (
	input  wire logic        i_clock,     // system clock
	input  wire logic        i_reset,     // async reset, active high
	smid_if.host             bus,         // two-wire link
	input  wire logic        i_hsel,      // slave select
	input  wire logic [31:0] i_haddr,     // address
	input  wire logic [1:0]  i_htrans,    // transfer type
	input  wire logic        i_hwrite,    // write strobe
	input  wire logic [2:0]  i_hsize,     // transfer size, words only
	input  wire logic [31:0] i_hwdata,    // write data
	input  wire logic        i_hready,    // bus ready
	output logic             o_hreadyout, // slave ready
	output logic [31:0]      o_hrdata,    // read data
	output logic             o_hresp      // response, always okay
);

	// ==========================================================================
	// bus slave
	logic        wr_pend_reg;
	logic [7:0]  wr_addr_reg;
	logic [12:0] cmd_reg;
	logic        cmd_go_reg;
	logic [7:0]  div_reg;
	logic        busy_reg;
	logic        ack_seen_reg;
	logic [7:0]  rx_reg;

	logic [31:0] status_word;
	assign status_word = {16'h0000, rx_reg, 6'h00, ack_seen_reg, busy_reg | cmd_go_reg};

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			o_hreadyout <= 1'b1;
			o_hrdata    <= 32'h0000_0000;
			o_hresp     <= 1'b0;
			cmd_reg     <= 13'h0000;
			cmd_go_reg  <= 1'b0;
			div_reg     <= `SMID_DIV_RESET;
		end else begin
			cmd_go_reg  <= 1'b0;
			wr_pend_reg <= 1'b0;
			if (i_hsel && i_htrans[1] && i_hready) begin
				wr_pend_reg <= i_hwrite;
				wr_addr_reg <= i_haddr[7:0];
				if (i_haddr[7:0] == `SMID_STATUS_OFS) begin
					o_hrdata <= status_word;
				end else if (i_haddr[7:0] == `SMID_DIV_OFS) begin
					o_hrdata <= {24'h000000, div_reg};
				end else if (i_haddr[7:0] == `SMID_CMD_OFS) begin
					o_hrdata <= {19'h00000, cmd_reg};
				end else begin
					o_hrdata <= 32'h0000_0000;
				end
			end
			if (wr_pend_reg) begin
				// a command written while one is running is dropped
				if (wr_addr_reg == `SMID_CMD_OFS && !(busy_reg || cmd_go_reg)) begin
					cmd_reg    <= i_hwdata[12:0];
					cmd_go_reg <= 1'b1;
				end else if (wr_addr_reg == `SMID_DIV_OFS) begin
					div_reg <= i_hwdata[7:0];
				end
			end
		end
	end

	// ==========================================================================
	// data line synchroniser; stage 1 is read only by stage 2
	logic sda_s1;
	logic sda_s2;
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
		end else begin
			sda_s1 <= bus.sda;
			sda_s2 <= sda_s1;
		end
	end

	// ==========================================================================
	// bit engine: four quarter-phases per start, bit or stop
	smid_pkg::smid_host_state_e state_reg;
	logic [1:0] phase_reg;
	logic [7:0] tick_cnt_reg;
	logic [3:0] bit_idx_reg;
	logic [7:0] shift_reg;
	logic       scl_oe_reg;
	logic       sda_oe_reg;

	logic tick;
	logic has_byte;
	assign tick     = (tick_cnt_reg >= div_reg);
	assign has_byte = cmd_reg[`SMID_CMD_WRITE_BIT] | cmd_reg[`SMID_CMD_READ_BIT];

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			state_reg    <= smid_pkg::HS_IDLE;
			phase_reg    <= 2'h0;
			tick_cnt_reg <= 8'h00;
			bit_idx_reg  <= 4'h0;
			shift_reg    <= 8'h00;
			scl_oe_reg   <= 1'b0;
			sda_oe_reg   <= 1'b0;
			busy_reg     <= 1'b0;
			ack_seen_reg <= 1'b0;
			rx_reg       <= 8'h00;
		end else if (state_reg == smid_pkg::HS_IDLE) begin
			tick_cnt_reg <= 8'h00;
			phase_reg    <= 2'h0;
			bit_idx_reg  <= 4'h0;
			if (cmd_go_reg) begin
				shift_reg <= cmd_reg[7:0];
				busy_reg  <= 1'b1;
				if (cmd_reg[`SMID_CMD_START_BIT]) begin
					state_reg <= smid_pkg::HS_START;
				end else if (has_byte) begin
					state_reg <= smid_pkg::HS_BIT;
				end else if (cmd_reg[`SMID_CMD_STOP_BIT]) begin
					state_reg <= smid_pkg::HS_STOP;
				end else begin
					busy_reg <= 1'b0;
				end
			end
		end else if (!tick) begin
			tick_cnt_reg <= tick_cnt_reg + 8'h01;
		end else begin
			tick_cnt_reg <= 8'h00;
			phase_reg    <= phase_reg + 2'h1;
			case (state_reg)
				smid_pkg::HS_START: begin
					// releasing data with the clock held low, then the clock, makes this a repeated start when the bus is held
					case (phase_reg)
						2'h0: begin
							sda_oe_reg <= 1'b0;
							scl_oe_reg <= 1'b1;
						end
						2'h1: scl_oe_reg <= 1'b0;
						2'h2: sda_oe_reg <= 1'b1;
						default: begin
							scl_oe_reg <= 1'b1;
							if (has_byte) begin
								state_reg <= smid_pkg::HS_BIT;
							end else if (cmd_reg[`SMID_CMD_STOP_BIT]) begin
								state_reg <= smid_pkg::HS_STOP;
							end else begin
								state_reg <= smid_pkg::HS_IDLE;
								busy_reg  <= 1'b0;
							end
						end
					endcase
				end
				smid_pkg::HS_BIT: begin
					case (phase_reg)
						2'h0: begin
							if (!bit_idx_reg[3]) begin
								sda_oe_reg <= cmd_reg[`SMID_CMD_WRITE_BIT] & ~shift_reg[7];
							end else begin
								sda_oe_reg <= cmd_reg[`SMID_CMD_READ_BIT] & ~cmd_reg[`SMID_CMD_NACK_BIT];
							end
						end
						2'h1: scl_oe_reg <= 1'b0;
						2'h2: begin
							if (!bit_idx_reg[3]) begin
								shift_reg <= {shift_reg[6:0], sda_s2};
							end else begin
								ack_seen_reg <= ~sda_s2;
							end
						end
						default: begin
							scl_oe_reg  <= 1'b1;
							bit_idx_reg <= bit_idx_reg + 4'h1;
							if (bit_idx_reg[3]) begin
								rx_reg      <= shift_reg;
								sda_oe_reg  <= 1'b0;
								bit_idx_reg <= 4'h0;
								if (cmd_reg[`SMID_CMD_STOP_BIT]) begin
									state_reg <= smid_pkg::HS_STOP;
								end else begin
									state_reg <= smid_pkg::HS_IDLE;
									busy_reg  <= 1'b0;
								end
							end
						end
					endcase
				end
				default: begin
					case (phase_reg)
						2'h0: sda_oe_reg <= 1'b1;
						2'h1: scl_oe_reg <= 1'b0;
						2'h2: sda_oe_reg <= 1'b0;
						default: begin
							state_reg <= smid_pkg::HS_IDLE;
							busy_reg  <= 1'b0;
						end
					endcase
				end
			endcase
		end
	end

	assign bus.scl_oe      = scl_oe_reg;
	assign bus.host_sda_oe = sda_oe_reg;

endmodule : smid_host

// *** testbench/smid_link_sva.sv ***
// assertions on the two-wire link and the client's write-cycle flags
`timescale 1ns/1ps
module smid_link_sva #(
	parameter int WRITE_CYCLE_CLKS = 20 // self-timed write length
) (
	input wire logic i_clock,     // system clock
	input wire logic i_reset,     // async reset
	input wire logic scl_oe,      // host pulls clock
	input wire logic host_sda_oe, // host pulls data
	input wire logic dev_sda_oe,  // client pulls data
	input wire logic scl,         // clock line
	input wire logic sda,         // data line
	input wire logic o_locked,    // user page locked
	input wire logic o_busy       // write cycle running
);
	int busy_cnt;

	// length of the running write cycle, bounded above
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			busy_cnt <= 0;
		end else begin
			busy_cnt <= o_busy ? busy_cnt + 1 : 0;
		end
	end

	default clocking @(posedge i_clock); endclocking
	default disable iff (i_reset);

	a_lock_stays: assert property (o_locked |=> o_locked) else $error("lock dropped");
	a_lock_after_cycle: assert property ($rose(o_locked) |-> $past(o_busy)) else $error("lock early");
	a_cycle_unlocked: assert property ($rose(o_busy) |-> !o_locked) else $error("cycle when locked");
	a_cycle_bus_free: assert property ($rose(o_busy) |-> scl && sda) else $error("cycle not after stop");
	a_cycle_min_len: assert property ($rose(o_busy) |-> o_busy [*8]) else $error("cycle too short");
	a_cycle_max_len: assert property (busy_cnt <= WRITE_CYCLE_CLKS + 1) else $error("cycle too long");
	a_busy_no_ack: assert property (o_busy |-> !dev_sda_oe) else $error("ack while busy");
	a_data_clock_low: assert property ($changed(dev_sda_oe) |-> !scl) else $error("data moved, clock high");
endmodule : smid_link_sva

// *** testbench/smid_tb.sv ***
// self-checking bench: host controller facing the client over the link
`timescale 1ns/1ps
`include "smid_regs.svh"
module smid_tb;
	localparam int          WCC = 20;
	localparam logic [23:0] ID  = {12'h3C1, 9'h0A7, 3'h5}; // arbitrary value
	localparam logic [12:0] W   = 13'h1 << `SMID_CMD_WRITE_BIT;
	localparam logic [12:0] SW  = W | (13'h1 << `SMID_CMD_START_BIT);
	localparam logic [12:0] R   = 13'h1 << `SMID_CMD_READ_BIT;
	localparam logic [12:0] P   = 13'h1 << `SMID_CMD_STOP_BIT;
	localparam logic [12:0] N   = 13'h1 << `SMID_CMD_NACK_BIT;
	logic        i_clock = 0, i_reset = 0, hsel = 0, hwrite = 0, wp = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, st;
	logic [1:0]  htrans = 0;
	wire         hrdy, hresp, locked, busy;
	int          error_cnt = 0, n_compared = 0;

	smid_if bus ();
	smid_host i_smid_host (.i_clock(i_clock), .i_reset(i_reset), .bus(bus.host), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
		.i_hready(hrdy), .o_hreadyout(hrdy), .o_hrdata(hrdata), .o_hresp(hresp));
	smid_device #(.SERIAL_NUMBER({8'hC3, 120'h0}), .MAKER_CODE(ID[23:12]), .DENSITY_CODE(ID[11:3]),
		.REVISION_CODE(ID[2:0]), .WRITE_CYCLE_CLKS(WCC)) i_smid_device (.i_clock(i_clock),
		.i_reset(i_reset), .bus(bus.device), .i_client_select_pin_2(1'b0), .i_client_select_pin_1(1'b0),
		.i_client_select_pin_0(1'b0), .i_write_protect(wp), .o_locked(locked), .o_busy(busy));
	smid_link_sva #(.WRITE_CYCLE_CLKS(WCC)) i_smid_link_sva (.i_clock(i_clock), .i_reset(i_reset),
		.scl_oe(bus.scl_oe), .host_sda_oe(bus.host_sda_oe), .dev_sda_oe(bus.dev_sda_oe), .scl(bus.scl),
		.sda(bus.sda), .o_locked(locked), .o_busy(busy));

	initial begin
		forever #5 i_clock = ~i_clock;
	end

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task print_verdict;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict

	task tmo;
		error_cnt++;
		$display("MISMATCH wait exp done seen hang");
		print_verdict;
	endtask : tmo

	task rdy_edge;
		int n;
		n = 0;
		do begin
			@(posedge i_clock);
			n++;
		end while (hrdy !== 1'b1 && n < 50);
		if (hrdy !== 1'b1) tmo;
	endtask : rdy_edge

	// one single-word transfer, called right after a rising edge
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		rdy_edge;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy_edge;
		r = hrdata;
	endtask : ahb

	// a new command is dropped while busy, so poll before returning
	task op(input logic [12:0] c);
		int n;
		n = 0;
		ahb(1'b1, `SMID_CMD_OFS, {19'h0, c}, st);
		do begin
			ahb(1'b0, `SMID_STATUS_OFS, 32'h0, st);
			n++;
		end while (st[0] !== 1'b0 && n < 500);
		if (st[0] !== 1'b0) tmo;
	endtask : op

	task wr(input logic [12:0] c, input logic ack, input string nm);
		op(c);
		chk(nm, st[1], ack);
	endtask : wr

	task rd(input logic [12:0] c, input logic [7:0] e, input string nm);
		op(c);
		chk(nm, st[15:8], e);
	endtask : rd

	task wbyte(input logic [15:0] a, input logic [7:0] d);
		int n;
		wr(SW | 13'hB0, 1'b1, "w dev");
		wr(W | a[15:8], 1'b1, "w hi");
		wr(W | a[7:0], 1'b1, "w lo");
		wr(W | P | d, 1'b1, "w data");
		n = 0;
		while (busy !== 1'b0 && n < 200) begin
			@(posedge i_clock);
			n++;
		end
		if (busy !== 1'b0) tmo;
	endtask : wbyte

	task rbyte(input logic [15:0] a, input logic [7:0] e, input string nm);
		wr(SW | 13'hB0, 1'b1, "r dev");
		wr(W | a[15:8], 1'b1, "r hi");
		wr(W | a[7:0], 1'b1, "r lo");
		wr(SW | 13'hB1, 1'b1, "r dev rd");
		rd(R | N | P, e, nm);
	endtask : rbyte

	// register map, response code and a divider write; the link then runs at the new divider
	task t_regs;
		ahb(1'b0, `SMID_DIV_OFS, 32'h0, st);
		chk("div reset", st, {24'h0, `SMID_DIV_RESET});
		ahb(1'b0, 8'h0C, 32'h0, st);
		chk("unmapped", st, 32'h0);
		chk("resp", hresp, 1'b0);
		ahb(1'b1, `SMID_DIV_OFS, 32'h6, st);
		ahb(1'b0, `SMID_DIV_OFS, 32'h0, st);
		chk("div write", st, 32'h6);
		$display("test registers done");
	endtask : t_regs

	task t_id;
		wr(SW | 13'hF8, 1'b1, "f8");
		wr(W | 13'hA0, 1'b1, "id sel");
		wr(SW | 13'hF9, 1'b1, "f9");
		rd(R, ID[23:16], "id0");
		rd(R, ID[15:8], "id1");
		rd(R, ID[7:0], "id2");
		rd(R | N | P, ID[23:16], "id wrap");
		wr(SW | 13'hF8, 1'b1, "f8 again");
		wr(W | P | 13'hA0, 1'b1, "sel stop");
		wr(SW | P | 13'hF9, 1'b0, "f9 after stop");
		$display("test id done");
	endtask : t_id

	task t_mem;
		wr(SW | P | 13'hB1, 1'b0, "current rd");
		wr(SW | 13'hB0, 1'b1, "dev");
		wr(W | P | 13'h00, 1'b0, "bad addr");
		wr(SW | 13'hF8, 1'b1, "f8 open");
		wr(SW | P | 13'hB0, 1'b0, "no stop");
		rbyte(16'h08FF, 8'hFF, "user blank");
		rd(R | N | P, 8'hFF, "dummy");
		wr(SW | 13'hB0, 1'b1, "dev");
		wr(W | 13'h08, 1'b1, "hi");
		wr(W | 13'hFF, 1'b1, "lo");
		wr(SW | 13'hB1, 1'b1, "dev rd");
		rd(R, 8'hFF, "byte 255");
		rd(R | N | P, 8'hC3, "wrap serial");
		wp <= 1'b1;
		wbyte(16'h0880, 8'h5A);
		rbyte(16'h0880, 8'hFF, "wp write");
		wp <= 1'b0;
		wbyte(16'h0880, 8'h5A);
		rbyte(16'h0880, 8'h5A, "user write");
		wbyte(16'h0810, 8'h5A);
		rbyte(16'h0810, 8'hFF, "reserved");
		$display("test memory done");
	endtask : t_mem

	task t_lock;
		wr(SW | 13'hB0, 1'b1, "chk dev");
		wr(W | P | 13'h06, 1'b1, "chk open");
		chk("cut short", locked, 1'b0);
		wp <= 1'b1;
		wbyte(16'h0600, 8'h00);
		chk("locked", locked, 1'b1);
		wr(SW | 13'hB0, 1'b1, "chk dev");
		wr(W | P | 13'h06, 1'b0, "chk shut");
		wp <= 1'b0;
		wbyte(16'h0890, 8'h11);
		rbyte(16'h0890, 8'hFF, "locked wr");
		$display("test lock done");
	endtask : t_lock

	initial begin
		// a rising reset edge at time zero, so the asynchronous reset branches really run
		i_reset <= 1'b1;
		repeat (4) @(posedge i_clock);
		i_reset <= 1'b0;
		repeat (3) @(posedge i_clock);
		t_regs;
		t_id;
		t_mem;
		t_lock;
		print_verdict;
	end
endmodule : smid_tb
